/* File: logic/pin_cfg_decoder.sv */
// Multi-mode pin configuration decoder with AXI4-Lite register access.
// Assumes pin classes and indices are static and synchronous to aclk.
`default_nettype none

module pin_cfg_decoder #(
  parameter logic [6:0] ADDR_BASE = pin_cfg_pkg::ADDR_BASE_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [1:0]  vout_fine_select_pin_class,
  input  wire logic [4:0]  vout_fine_select_pin_index,
  input  wire logic [1:0]  vout_coarse_select_pin_class,
  input  wire logic [4:0]  vout_coarse_select_pin_index,
  input  wire logic [1:0]  bus_addr_select_pin_a_class,
  input  wire logic [4:0]  bus_addr_select_pin_a_index,
  input  wire logic [1:0]  bus_addr_select_pin_b_class,
  input  wire logic [4:0]  bus_addr_select_pin_b_index,
  input  wire logic [9:0]  measured_vout,
  output logic      [9:0]  vout_setpoint,
  output logic      [9:0]  vout_limit,
  output logic      [6:0]  bus_addr,
  output logic             trim_mode,
  output logic             irq,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp
);
  import pin_cfg_pkg::*;

  // ==========================================
  // Elaboration check
  if (ADDR_BASE > ADDR_LIMIT) begin : g_bad_base
    $error("ADDR_BASE leaves no room for pin offsets");
  end

  regs_s r_reg;
  regs_s r_next;

  // ==========================================
  // Pin decode
  logic        f_res;
  logic        c_res;
  logic        is_trim;
  logic [9:0]  fine_step_index;
  logic [9:0]  coarse_step_index;
  logic [9:0]  sp_raw;
  logic [9:0]  sp_dec;
  logic [13:0] lim_prod;
  logic [9:0]  lim_dec;
  logic [5:0]  sel_a;
  logic [5:0]  sel_b;
  logic [6:0]  addr_dec;
  logic [3:0]  strap_ix;

  // Pin code: strap level, or resistor index above the strap codes
  function automatic logic [5:0] pin_code(input logic [1:0] c, input logic [4:0] i);
    logic [4:0] ic;
    ic = (i > IDX_MAX) ? IDX_MAX : i;
    if (c == CLS_RES) begin
      pin_code = STRAP_CODES + {1'b0, ic};
    end else begin
      pin_code = {4'h0, c};
    end
  endfunction

  // Limit a voltage resistor index to the table span
  function automatic logic [9:0] vsel_idx(input logic [1:0] c, input logic [4:0] i);
    if (c != CLS_RES) begin
      vsel_idx = 10'h000;
    end else if (i > IDX_VSEL_MAX) begin
      vsel_idx = {5'h00, IDX_VSEL_MAX};
    end else begin
      vsel_idx = {5'h00, i};
    end
  endfunction

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int k = 0; k < 4; k++) begin
      merge[k*8 +: 8] = s[k] ? d[k*8 +: 8] : o[k*8 +: 8];
    end
  endfunction

  // Set point, limit and address from the pin classes
  always_comb begin
    f_res = (vout_fine_select_pin_class == CLS_RES);
    c_res = (vout_coarse_select_pin_class == CLS_RES);
    is_trim = f_res && (vout_fine_select_pin_index == IDX_TRIM);
    fine_step_index = is_trim ? 10'h000 :
                      vsel_idx(vout_fine_select_pin_class, vout_fine_select_pin_index);
    coarse_step_index = vsel_idx(vout_coarse_select_pin_class, vout_coarse_select_pin_index);
    strap_ix = 4'(vout_coarse_select_pin_class * 2'h3) + {2'h0, vout_fine_select_pin_class};
    if (f_res || c_res) begin
      sp_raw = 10'(fine_step_index + coarse_step_index * COARSE_MULT);
    end else begin
      sp_raw = STRAP_VOUT[strap_ix];
    end
    if (sp_raw < VOUT_LO) begin
      sp_dec = VOUT_LO;
    end else if (sp_raw > VOUT_HI) begin
      sp_dec = VOUT_HI;
    end else begin
      sp_dec = sp_raw;
    end
    lim_prod = {4'h0, sp_dec} * MARGIN_NUM;
    lim_dec = 10'(lim_prod / MARGIN_DEN);
    sel_a = pin_code(bus_addr_select_pin_a_class, bus_addr_select_pin_a_index);
    sel_b = pin_code(bus_addr_select_pin_b_class, bus_addr_select_pin_b_index);
    addr_dec = 7'(ADDR_BASE + {1'b0, sel_a} + 7'(sel_b * STRAP_CODES));
  end

  // ==========================================
  // Register bus and state update
  logic        do_write;
  logic [31:0] wmerged;
  logic [31:0] old_word;
  logic [2:0]  ev;
  logic [2:0]  clr;

  always_comb begin
    r_next = r_reg;
    ev = 3'h0;
    clr = 3'h0;
    old_word = 32'h0;
    wmerged = 32'h0;
    do_write = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;
    // Accept address and data in either order
    if (awvalid && r_reg.awready) begin
      r_next.aw_have = 1'b1;
      r_next.awaddr = awaddr;
    end
    if (wvalid && r_reg.wready) begin
      r_next.w_have = 1'b1;
      r_next.wdata = wdata;
      r_next.wstrb = wstrb;
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end
    // Register writes
    if (do_write) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      case (r_reg.awaddr)
        OFF_VOUT:  old_word = {22'h0, r_reg.vout};
        OFF_ALERT: old_word = {22'h0, r_reg.alert_hi};
        OFF_IRQ_EN: old_word = {29'h0, r_reg.irq_en};
        default:   old_word = 32'h0;
      endcase
      wmerged = merge(old_word, r_reg.wdata, r_reg.wstrb);
      case (r_reg.awaddr)
        OFF_CTRL: begin
          if (wmerged[0]) begin
            r_next.st = ST_SAMPLE;
          end
        end
        OFF_VOUT: begin
          if (wmerged[31:0] < {22'h0, VOUT_LO}) begin
            r_next.vout = VOUT_LO;
            ev[EV_CLAMP] = 1'b1;
          end else if (wmerged[31:0] > {22'h0, VOUT_HI}) begin
            r_next.vout = VOUT_HI;
            ev[EV_CLAMP] = 1'b1;
          end else begin
            r_next.vout = wmerged[9:0];
          end
        end
        OFF_ALERT:   r_next.alert_hi = wmerged[9:0];
        OFF_IRQ_CLR: clr = wmerged[2:0];
        OFF_IRQ_EN:  r_next.irq_en = wmerged[2:0];
        OFF_VMAX, OFF_ADDR, OFF_PINS, OFF_IRQ_ST: begin
          r_next.bresp = RESP_SLVERR;
        end
        default: r_next.bresp = RESP_SLVERR;
      endcase
    end
    // Register reads
    if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
    if (arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      case (araddr)
        OFF_CTRL:   r_next.rdata = {31'h0, r_reg.st == ST_SAMPLE};
        OFF_VOUT:   r_next.rdata = {22'h0, r_reg.vout};
        OFF_VMAX:   r_next.rdata = {22'h0, r_reg.vmax};
        OFF_ADDR:   r_next.rdata = {25'h0, r_reg.addr};
        OFF_PINS:   r_next.rdata = {23'h0, r_reg.trim, r_reg.pins};
        OFF_ALERT:  r_next.rdata = {22'h0, r_reg.alert_hi};
        OFF_IRQ_ST: r_next.rdata = {29'h0, r_reg.irq_st};
        OFF_IRQ_EN: r_next.rdata = {29'h0, r_reg.irq_en};
        default: begin
          r_next.rdata = 32'h0;
          r_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready = !r_next.w_have && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
    // Pin sampling overrides a same-cycle set point write
    case (r_reg.st)
      ST_SAMPLE: begin
        r_next.vout = sp_dec;
        r_next.vmax = lim_dec;
        r_next.addr = addr_dec;
        r_next.trim = is_trim;
        r_next.pins = {bus_addr_select_pin_b_class, bus_addr_select_pin_a_class,
                       vout_coarse_select_pin_class, vout_fine_select_pin_class};
        r_next.st = ST_RUN;
        ev[EV_SAMPLED] = 1'b1;
      end
      ST_RUN: begin
      end
      default: r_next.st = ST_SAMPLE;
    endcase
    // Alert on monitored output above its limit
    if (measured_vout > r_reg.alert_hi) begin
      ev[EV_ALERT] = 1'b1;
    end
    r_next.irq_st = (r_reg.irq_st & ~clr) | ev;
    r_next.irq = |(r_next.irq_st & r_next.irq_en);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // Outputs
  assign vout_setpoint = r_reg.vout;
  assign vout_limit    = r_reg.vmax;
  assign bus_addr      = r_reg.addr;
  assign trim_mode     = r_reg.trim;
  assign irq           = r_reg.irq;
  assign awready       = r_reg.awready;
  assign wready        = r_reg.wready;
  assign bvalid        = r_reg.bvalid;
  assign bresp         = r_reg.bresp;
  assign arready       = r_reg.arready;
  assign rvalid        = r_reg.rvalid;
  assign rdata         = r_reg.rdata;
  assign rresp         = r_reg.rresp;

  // ==========================================
  // Assertions
  logic vout_wr;
  assign vout_wr = do_write && (r_reg.awaddr == OFF_VOUT);

  a_pwrup_sample: assert property (@(posedge aclk)
    $rose(aresetn) |-> r_reg.st == ST_SAMPLE ##1 r_reg.st == ST_RUN)
    else $error("no sampling after reset");
  a_restore_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_RUN && do_write && r_reg.awaddr == OFF_CTRL && r_reg.wdata[0] && r_reg.wstrb[0])
    |=> r_reg.st == ST_SAMPLE ##1 r_reg.st == ST_RUN)
    else $error("restore did not resample");
  a_limit_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_SAMPLE |=> 14'(r_reg.vmax) == 14'(14'(r_reg.vout) * 14'd11 / 14'd10))
    else $error("limit not ten percent above set point");
  a_strap_top: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_SAMPLE && vout_fine_select_pin_class == CLS_HIGH
     && vout_coarse_select_pin_class == CLS_OPEN) |=> r_reg.vout == 10'd180)
    else $error("strap open-high not 1.8 V");
  a_res_formula: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_SAMPLE && f_res && c_res && vout_fine_select_pin_index <= 5'd24
     && vout_coarse_select_pin_index >= 5'd3 && vout_coarse_select_pin_index <= 5'd19)
    |=> r_reg.vout == 10'($past(vout_fine_select_pin_index) + 25 * $past(vout_coarse_select_pin_index)))
    else $error("resistor set point formula wrong");
  a_trim_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_SAMPLE) |=> trim_mode == ($past(vout_fine_select_pin_class) == CLS_RES
    && $past(vout_fine_select_pin_index) == 5'd25))
    else $error("trim mode select wrong");
  a_addr_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_SAMPLE && bus_addr_select_pin_a_class == CLS_LOW
     && bus_addr_select_pin_b_class == CLS_HIGH) |=> bus_addr == 7'(ADDR_BASE + 7'd6))
    else $error("address from straps wrong");
  a_vout_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_RUN && !vout_wr) |=> $stable(vout_setpoint))
    else $error("set point changed without cause");
  a_vout_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_RUN && vout_wr && r_reg.wstrb == 4'hf && r_reg.wdata >= 32'd60
     && r_reg.wdata <= 32'd500) |=> vout_setpoint == $past(r_reg.wdata[9:0]) && bvalid)
    else $error("host set point not applied");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(r_reg.irq_st & r_reg.irq_en))
    else $error("interrupt level mismatch");

  // ==========================================
  // Bus answer and storage assertions
  // Read answer stands one edge after the address
  a_rd_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready) |=> rvalid)
    else $error("read answer late");

  // Host set point writes answer okay
  a_vout_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    vout_wr |=> bvalid && bresp == RESP_OKAY)
    else $error("set point write refused");

  // Oversized host set point clamps and flags
  a_clamp_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_RUN && vout_wr && r_reg.wstrb == 4'hf && r_reg.wdata > 32'd500)
    |=> vout_setpoint == VOUT_HI && r_reg.irq_st[EV_CLAMP])
    else $error("high set point not clamped");

  // Undersized host set point clamps and flags
  a_clamp_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_RUN && vout_wr && r_reg.wstrb == 4'hf && r_reg.wdata < 32'd60)
    |=> vout_setpoint == VOUT_LO && r_reg.irq_st[EV_CLAMP])
    else $error("low set point not clamped");

  // Limit and address move only by sampling
  a_pin_only: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_RUN |=> $stable(vout_limit) && $stable(bus_addr))
    else $error("limit or address moved without sampling");

  // Read-only places refuse writes
  a_ro_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && (r_reg.awaddr == OFF_VMAX || r_reg.awaddr == OFF_ADDR)) |=> bvalid && bresp == RESP_SLVERR)
    else $error("read-only write accepted");

  // Every sampling pass sets its status bit
  a_sample_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_SAMPLE |=> r_reg.irq_st[EV_SAMPLED])
    else $error("sampling not flagged");

  // Alert condition sets its status bit
  a_alert_set: assert property (@(posedge aclk) disable iff (!aresetn)
    measured_vout > r_reg.alert_hi |=> r_reg.irq_st[EV_ALERT])
    else $error("alert not flagged");

  // Both voltage straps low give the lowest point
  a_strap_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_SAMPLE && vout_fine_select_pin_class == CLS_LOW
     && vout_coarse_select_pin_class == CLS_LOW) |=> vout_setpoint == 10'd60)
    else $error("strap low-low not 0.6 V");

  // Trim mapping takes the point from the coarse pin
  a_trim_point: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_reg.st == ST_SAMPLE && is_trim && c_res && vout_coarse_select_pin_index >= 5'd3
     && vout_coarse_select_pin_index <= 5'd20)
    |=> vout_setpoint == 10'(25 * $past(vout_coarse_select_pin_index)))
    else $error("trim set point wrong");

  // Pin classes recorded at sampling
  a_pins_record: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == ST_SAMPLE |=> r_reg.pins == {$past(bus_addr_select_pin_b_class),
      $past(bus_addr_select_pin_a_class), $past(vout_coarse_select_pin_class),
      $past(vout_fine_select_pin_class)})
    else $error("pin classes not recorded");

endmodule

`default_nettype wire

/* File: logic/pin_cfg_pkg.sv */
// Constants, register map and state type of the pin configuration decoder.
// Assumes pin classes and resistor indices arrive from an analog front end.
//
// Summary of operation
// - Sample pins at power-up and on restore
// - Classify each pin: low, open, high, resistor
// - One strap pin picks three, two pick nine
// - Resistor mode decodes up to 31 values
// - Address and limit only from pins
// - Bus address from both address pins
// - Voltage limit is pin-sampled set point plus 10%
// - Strap pair maps to nine set points
// - Resistor pair gives 0.6-5.0 V, 10 mV
// - Set point is fine plus 25 coarse
// - Voltage resistor index spans 0 to 24
// - 110k on fine pin selects trim mapping
// - Decoded values readable by host; only set point overwritable
// - Host may program 0.6 to 5.0 V
// - Monitored limit raises alert to host
`default_nettype none

package pin_cfg_pkg;

  // ==========================================
  // Pin classes and decode limits
  localparam logic [1:0] CLS_LOW  = 2'h0;
  localparam logic [1:0] CLS_OPEN = 2'h1;
  localparam logic [1:0] CLS_HIGH = 2'h2;
  localparam logic [1:0] CLS_RES  = 2'h3;
  localparam int         VIL_MV   = 800;  // Low comparator threshold
  localparam int         VIH_MV   = 2000; // High comparator threshold
  localparam logic [4:0] IDX_VSEL_MAX = 5'h18;
  localparam logic [4:0] IDX_TRIM     = 5'h19;
  localparam logic [4:0] IDX_MAX      = 5'h1e;
  localparam logic [5:0] STRAP_CODES  = 6'h03;

  // ==========================================
  // Set point arithmetic, 10 mV units
  localparam logic [9:0]  VOUT_LO     = 10'h03c;
  localparam logic [9:0]  VOUT_HI     = 10'h1f4;
  localparam logic [9:0]  COARSE_MULT = 10'h019;
  localparam logic [13:0] MARGIN_NUM  = 14'h000b;
  localparam logic [13:0] MARGIN_DEN  = 14'h000a;
  localparam logic [0:8][9:0] STRAP_VOUT = {
    10'h03c, 10'h050, 10'h064,
    10'h078, 10'h096, 10'h0b4,
    10'h0fa, 10'h14a, 10'h1f4};
  localparam logic [6:0] ADDR_BASE_DEF = 7'h20;
  localparam logic [6:0] ADDR_LIMIT    = 7'h77;

  // ==========================================
  // Register map and responses
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_VOUT    = 8'h04;
  localparam logic [7:0] OFF_VMAX    = 8'h08;
  localparam logic [7:0] OFF_ADDR    = 8'h0c;
  localparam logic [7:0] OFF_PINS    = 8'h10;
  localparam logic [7:0] OFF_ALERT   = 8'h14;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h20;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int EV_SAMPLED = 0;
  localparam int EV_ALERT   = 1;
  localparam int EV_CLAMP   = 2;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b10
  } state_e;

  typedef struct packed {
    state_e      st;
    logic [9:0]  vout;
    logic [9:0]  vmax;
    logic [6:0]  addr;
    logic        trim;
    logic [7:0]  pins;
    logic [9:0]  alert_hi;
    logic [2:0]  irq_st;
    logic [2:0]  irq_en;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } regs_s;

  localparam regs_s REGS_RST = '{st: ST_SAMPLE, alert_hi: 10'h3ff, default: '0};

endpackage

`default_nettype wire

/* File: verif/pin_strap_board.sv */
// Board model: straps and resistors on the two voltage select pins.
// Assumes the bench picks strap classes or a target set point in 10 mV.
`default_nettype none

module pin_strap_board (
  input  wire logic       aclk,
  input  wire logic [1:0] fine_cls,
  input  wire logic [1:0] coarse_cls,
  input  wire logic [9:0] target,
  input  wire logic       trim_sel,
  output logic      [1:0] f_cls,
  output logic      [4:0] f_idx,
  output logic      [1:0] c_cls,
  output logic      [4:0] c_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] junk_reg = 5'h0a;
  logic [9:0] ci;

  // ==========================================
  // Index lines of strapped pins carry no value
  always @(posedge aclk) junk_reg <= ~junk_reg + 5'h03;

  // Resistor pair chosen from the target voltage
  always_comb begin
    ci = target / 10'h019;
    f_cls = trim_sel ? 2'h3 : fine_cls;
    c_cls = coarse_cls;
    c_idx = (c_cls == 2'h3) ? ci[4:0] : junk_reg;
    f_idx = trim_sel ? 5'h19 : (f_cls == 2'h3) ? 5'(target - ci * 10'h019) : junk_reg;
  end
endmodule

`default_nettype wire

/* File: verif/tb_multimode_pin_config_decoder.sv */
// Self-checking bench of the pin configuration decoder.
// Assumes a board model on the voltage pins and an AXI4-Lite host here.
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb_multimode_pin_config_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_cfg_pkg::*;
  localparam logic [6:0] ABASE = 7'h20;
  localparam int LIMIT = 20000;
  logic aclk = 0, aresetn = 0, trim = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, trim_mode;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, fc = 0, cc = 0;
  logic [1:0] bus_addr_select_pin_a_class = 0, bus_addr_select_pin_b_class = 0;
  logic [4:0] bus_addr_select_pin_a_index = 0, bus_addr_select_pin_b_index = 0;
  logic [1:0] vout_fine_select_pin_class, vout_coarse_select_pin_class;
  logic [4:0] vout_fine_select_pin_index, vout_coarse_select_pin_index;
  logic [9:0] measured_vout = 0, tg = 0, vout_setpoint, vout_limit, t;
  logic [6:0] bus_addr, ea;
  logic [15:0] lfsr = 16'h004b;
  logic [33:0] exp_r[$], er;
  logic [1:0] exp_b[$], eb;
  int errors = 0, checks = 0, cyc = 0, i;
  int sv[9] = '{60, 80, 100, 120, 150, 180, 250, 330, 500};

  always #2.5 aclk = ~aclk;

  pin_cfg_decoder #(.ADDR_BASE(ABASE)) DUT (.aclk, .aresetn, .vout_fine_select_pin_class,
    .vout_fine_select_pin_index, .vout_coarse_select_pin_class, .vout_coarse_select_pin_index,
    .bus_addr_select_pin_a_class, .bus_addr_select_pin_a_index, .bus_addr_select_pin_b_class,
    .bus_addr_select_pin_b_index, .measured_vout, .vout_setpoint, .vout_limit, .bus_addr, .trim_mode,
    .irq, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  pin_strap_board board (.aclk, .fine_cls(fc), .coarse_cls(cc), .target(tg), .trim_sel(trim),
    .f_cls(vout_fine_select_pin_class), .f_idx(vout_fine_select_pin_index),
    .c_cls(vout_coarse_select_pin_class), .c_idx(vout_coarse_select_pin_index));

  // ==========================================
  // Host bus tasks and result monitor
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    exp_r.push_back({r, d});
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
  endtask

  task automatic restore();
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    repeat (3) @(posedge aclk);
  endtask

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Oldest note against each response
  always @(posedge aclk) begin
    if (rvalid && rready && exp_r.size() > 0) begin
      er = exp_r.pop_front();
      `CHK({rresp, rdata}, er)
    end
    if (bvalid && bready && exp_b.size() > 0) begin
      eb = exp_b.pop_front();
      `CHK(bresp, eb)
    end
  end

  task automatic end_of_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_VOUT, 32'd60);
    rd(OFF_IRQ_ST, 32'h1);
    rd(OFF_ALERT, 32'h3ff);
    rd(OFF_IRQ_EN, 32'h0);
    rd(OFF_CTRL, 32'h0);
    // Strap pairs and address straps
    for (i = 0; i < 9; i++) begin
      fc <= 2'(i % 3); cc <= 2'(i / 3);
      bus_addr_select_pin_a_class <= 2'(i % 3); bus_addr_select_pin_b_class <= 2'(i / 3);
      restore();
      ea = 7'(ABASE + i % 3 + 3 * (i / 3));
      rd(OFF_VOUT, sv[i]);
      rd(OFF_VMAX, sv[i] * 11 / 10);
      rd(OFF_ADDR, {25'h0, ea});
      rd(OFF_PINS, {24'h0, 2'(i / 3), 2'(i % 3), 2'(i / 3), 2'(i % 3)});
      `CHK(bus_addr, ea)
      `CHK(vout_setpoint, 10'(sv[i]))
      `CHK(vout_limit, 10'(sv[i] * 11 / 10))
    end
    // Resistor pairs from random targets
    for (i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      t = 10'(60 + lfsr % 441);
      fc <= 3; cc <= 3; tg <= t;
      bus_addr_select_pin_a_class <= 3; bus_addr_select_pin_a_index <= 5'(lfsr[14:3] % 31);
      bus_addr_select_pin_b_class <= 2'(lfsr[9:6] % 3);
      restore();
      ea = 7'(ABASE + 3 + bus_addr_select_pin_a_index + 3 * bus_addr_select_pin_b_class);
      rd(OFF_VOUT, t);
      rd(OFF_VMAX, t * 11 / 10);
      rd(OFF_ADDR, {25'h0, ea});
    end
    // Trim mapping from the fine pin
    trim <= 1; tg <= 10'd100;
    restore();
    rd(OFF_VOUT, 32'd100);
    rd(OFF_PINS, {23'h0, 1'b1, bus_addr_select_pin_b_class, 2'h3, 2'h3, 2'h3});
    `CHK(trim_mode, 1'b1)
    trim <= 0;
    // Host overrides and read-only places
    wr(OFF_IRQ_CLR, 32'h7, RESP_OKAY);
    wr(OFF_VOUT, 32'd200, RESP_OKAY);
    rd(OFF_VOUT, 32'd200);
    wr(OFF_VOUT, 32'd700, RESP_OKAY);
    rd(OFF_VOUT, 32'd500);
    rd(OFF_IRQ_ST, 32'h4);
    wr(OFF_VOUT, 32'd16, RESP_OKAY);
    rd(OFF_VOUT, 32'd60);
    rd(OFF_VMAX, 32'd110);
    wr(OFF_VMAX, 32'd50, RESP_SLVERR);
    wr(OFF_ADDR, 32'h11, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    // Held settings until a restore
    wr(OFF_VOUT, 32'd200, RESP_OKAY);
    fc <= 2; cc <= 2; bus_addr_select_pin_a_class <= 0; bus_addr_select_pin_b_class <= 0;
    repeat (4) @(posedge aclk);
    rd(OFF_VOUT, 32'd200);
    rd(OFF_ADDR, {25'h0, ea});
    restore();
    rd(OFF_VOUT, 32'd500);
    rd(OFF_ADDR, {25'h0, ABASE});
    // Alert raise, mask and clear
    wr(OFF_IRQ_CLR, 32'h7, RESP_OKAY);
    wr(OFF_ALERT, 32'd300, RESP_OKAY);
    measured_vout <= 10'd400;
    wr(OFF_IRQ_EN, 32'h2, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    rd(OFF_IRQ_ST, 32'h2);
    wr(OFF_IRQ_EN, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    measured_vout <= 10'd100;
    wr(OFF_IRQ_CLR, 32'h2, RESP_OKAY);
    rd(OFF_IRQ_ST, 32'h0);
    rd(OFF_ALERT, 32'd300);
    // Low byte lane only: upper bits of the limit kept
    wstrb <= 4'h1;
    wr(OFF_ALERT, 32'hffff_ff55, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFF_ALERT, 32'h0000_0155);
    repeat (4) @(posedge aclk);
    end_of_test();
  end
endmodule

`default_nettype wire
